// ==== verilog/qpcd_defs.vh ====
`ifndef QPCD_DEFS_VH
`define QPCD_DEFS_VH
// Instruction byte fields
`define QPCD_OPC_MSB 7
`define QPCD_OPC_LSB 4
`define QPCD_RSEL_MSB 3
`define QPCD_RSEL_LSB 2
`define QPCD_PSEL_MSB 1
`define QPCD_PSEL_LSB 0
// Opcodes
`define QPCD_OP_RD_WPR 4'h9
`define QPCD_OP_WR_WPR 4'hA
`define QPCD_OP_RD_SSR 4'hB
`define QPCD_OP_WR_SSR 4'hC
`define QPCD_OP_XFR_S2W 4'hD
`define QPCD_OP_XFR_W2S 4'hE
`define QPCD_OP_GXFR_S2W 4'h1
`define QPCD_OP_GXFR_W2S 4'h8
`define QPCD_OP_INCDEC 4'h2
// Slave address
`define QPCD_TYPE_ID 4'h6
// Reset values and wiper position limits
`define QPCD_WPR_RST 8'h00
`define QPCD_SSR_RST 8'h00
`define QPCD_POS_MAX 8'hFF
`define QPCD_POS_MIN 8'h00
// Timing, clock 200 MHz
`define QPCD_CLK_MHZ 200
`define QPCD_SETTLE_NS 1000
`define QPCD_SETTLE_CYC (((`QPCD_SETTLE_NS) * (`QPCD_CLK_MHZ) + 999) / 1000)
`define QPCD_NVW_US 5000
`define QPCD_NVW_CYC ((`QPCD_NVW_US) * (`QPCD_CLK_MHZ))
`endif

// ==== verilog/qpcd_sync.v ====
`timescale 1ns/10ps
module qpcd_sync (
    // Clock and reset
    input wire core_clk,
    input wire srst,
    input wire clk_en,
    // Asynchronous level in, synchronised level out
    input wire async_in,
    output reg sync_out
);
    reg meta_reg;

    always @(posedge core_clk) begin
        if (srst) begin
            meta_reg <= 1'b1;
            sync_out <= 1'b1;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // qpcd_sync

// ==== verilog/qpcd_decoder.v ====
`timescale 1ns/10ps
`include "qpcd_defs.vh"
// Contract
// - Instruction byte: opcode high nibble, register select, then pot select lowest.
// - Pot select picks the pot; register select picks the stored setting.
// - Opcode 1001, reg 00 returns the wiper position byte.
// - Opcode 1010, reg 00 loads the data byte into the wiper position.
// - Opcode 1011 returns the selected stored setting.
// - Opcode 1100 writes the data byte to stored setting, nonvolatile.
// - Opcode 1101 copies stored setting into the wiper position.
// - Opcode 1110 copies wiper position into stored setting, nonvolatile.
// - Opcode 0001, pot 00 copies stored setting into all four wipers.
// - Opcode 1000, pot 00 copies all wipers into their stored settings.
// - Opcode 0010, reg 00 enables stepping of the selected wiper.
// - Transfer instructions end with the instruction byte, no data byte.
// - Read/write instructions use address, instruction and one data byte.
// - Wiper output follows a stored-to-wiper transfer only after a settle delay.
// - Wiper-to-stored transfers take at least the nonvolatile write time.
// - Clock high with data high steps wiper toward high terminal.
// - Clock high with data low steps wiper toward low terminal.
// - Acknowledge address, instruction and written data byte.
// - Address byte is fixed type nibble then the four address input levels.
// - No address acknowledge during a nonvolatile write started at stop.
// - Write protect low blocks all nonvolatile stored-setting writes.
module qpcd_decoder (
    // Clock, reset, enable
    input wire core_clk,
    input wire srst,
    input wire clk_en,
    // Serial bus pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Device pins
    input wire [3:0] device_addr_inputs,
    input wire write_protect_n,
    // Wiper positions to the resistor arrays
    output reg [31:0] wiper_out,
    // Nonvolatile write in progress
    output wire nv_busy
);
    localparam [5:0] ST_IDLE = 6'b00_0001;
    localparam [5:0] ST_ADDR = 6'b00_0010;
    localparam [5:0] ST_INSTR = 6'b00_0100;
    localparam [5:0] ST_WDATA = 6'b00_1000;
    localparam [5:0] ST_RDATA = 6'b01_0000;
    localparam [5:0] ST_STEP = 6'b10_0000;

    wire scl_s;
    wire sda_s;
    reg scl_d_reg;
    reg sda_d_reg;
    reg [5:0] state_reg;
    reg [7:0] shift_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] instr_reg;
    reg ack_reg;
    reg drive_reg;
    reg [7:0] wiper_position_reg [0:3];
    reg [7:0] stored_setting_reg [0:15];
    reg [31:0] nv_cnt_reg;
    reg pend_nv_reg;
    reg [3:0] pend_mask_reg;
    reg [1:0] pend_rsel_reg;
    reg [7:0] pend_data_reg;
    reg pend_data_use_reg;
    reg [15:0] settle_cnt_reg;
    integer i;
    wire [3:0] addr_s;
    wire wp_sync_n;
    genvar g;
    // Settle count trimmed to the counter width on purpose
    localparam [31:0] SETTLE_CYC = `QPCD_SETTLE_CYC;

    qpcd_sync u_scl (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .async_in(scl_in), .sync_out(scl_s));
    qpcd_sync u_sda (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .async_in(sda_in), .sync_out(sda_s));
    // Straps and write protect are pins too, so they get the same two flops
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_addr_sync
            qpcd_sync u_addr (
                .core_clk(core_clk),
                .srst(srst),
                .clk_en(clk_en),
                .async_in(device_addr_inputs[g]),
                .sync_out(addr_s[g])
            );
        end
    endgenerate
    qpcd_sync u_wp (
        .core_clk(core_clk),
        .srst(srst),
        .clk_en(clk_en),
        .async_in(write_protect_n),
        .sync_out(wp_sync_n)
    );

    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire [3:0] opc = instr_reg[`QPCD_OPC_MSB:`QPCD_OPC_LSB];
    wire [1:0] rsel = instr_reg[`QPCD_RSEL_MSB:`QPCD_RSEL_LSB];
    wire [1:0] psel = instr_reg[`QPCD_PSEL_MSB:`QPCD_PSEL_LSB];
    wire [3:0] ssr_idx = {psel, rsel};
    wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
    wire [3:0] rx_opc = rx_byte[7:4];
    wire rx_r0 = (rx_byte[3:2] == 2'b00);
    wire rx_p0 = (rx_byte[1:0] == 2'b00);
    wire nv_ok = wp_sync_n;
    wire [7:0] sel_wpr = wiper_position_reg[psel];

    assign nv_busy = (nv_cnt_reg != 32'h0000_0000);
    assign sda_oe = drive_reg;
    assign sda_out = 1'b0;

    // Bit engine and command decode
    always @(posedge core_clk) begin
        if (srst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            instr_reg <= 8'h00;
            ack_reg <= 1'b0;
            drive_reg <= 1'b0;
            pend_nv_reg <= 1'b0;
            pend_mask_reg <= 4'h0;
            pend_rsel_reg <= 2'b00;
            pend_data_reg <= 8'h00;
            pend_data_use_reg <= 1'b0;
            nv_cnt_reg <= 32'h0000_0000;
            settle_cnt_reg <= 16'h0000;
            wiper_out <= 32'h0000_0000;
            for (i = 0; i < 4; i = i + 1) begin
                wiper_position_reg[i] <= `QPCD_WPR_RST;
            end
            for (i = 0; i < 16; i = i + 1) begin
                stored_setting_reg[i] <= `QPCD_SSR_RST;
            end
        end else if (clk_en) begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            // Settle delay gates wiper output update
            if (settle_cnt_reg != 16'h0000) begin
                settle_cnt_reg <= settle_cnt_reg - 16'h0001;
            end else begin
                for (i = 0; i < 4; i = i + 1) begin
                    wiper_out[i*8 +: 8] <= wiper_position_reg[i];
                end
            end
            if (nv_busy) begin
                nv_cnt_reg <= nv_cnt_reg - 32'h0000_0001;
            end
            if (start_cond) begin
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                ack_reg <= 1'b0;
                drive_reg <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                drive_reg <= 1'b0;
                ack_reg <= 1'b0;
                if (pend_nv_reg && nv_ok && !nv_busy) begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (pend_mask_reg[i]) begin
                            stored_setting_reg[{i[1:0], pend_rsel_reg}] <=
                                pend_data_use_reg ? pend_data_reg : wiper_position_reg[i];
                        end
                    end
                    nv_cnt_reg <= `QPCD_NVW_CYC;
                end
                pend_nv_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        // Ack of a two-byte command finishes here
                        if (ack_reg && scl_fall) begin
                            ack_reg <= ~drive_reg;
                            drive_reg <= ~drive_reg;
                        end else if (!ack_reg) begin
                            drive_reg <= 1'b0;
                        end
                    end
                    ST_ADDR, ST_INSTR, ST_WDATA: begin
                        if (ack_reg) begin
                            if (scl_fall) begin
                                // Pull on the eighth fall, free on the ninth, never while clock is high
                                ack_reg <= ~drive_reg;
                                drive_reg <= ~drive_reg;
                            end
                        end else if (scl_rise) begin
                            shift_reg <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == 4'h7) begin
                                bit_cnt_reg <= 4'h0;
                                case (state_reg)
                                    ST_ADDR: begin
                                        if (rx_byte == {`QPCD_TYPE_ID, addr_s} && !nv_busy) begin
                                            ack_reg <= 1'b1;
                                            state_reg <= ST_INSTR;
                                        end else begin
                                            state_reg <= ST_IDLE;
                                        end
                                    end
                                    ST_INSTR: begin
                                        instr_reg <= rx_byte;
                                        ack_reg <= 1'b1;
                                        state_reg <= ST_IDLE;
                                        case (rx_opc)
                                            `QPCD_OP_RD_WPR: if (rx_r0) state_reg <= ST_RDATA;
                                            `QPCD_OP_RD_SSR: state_reg <= ST_RDATA;
                                            `QPCD_OP_WR_WPR: if (rx_r0) state_reg <= ST_WDATA;
                                            `QPCD_OP_WR_SSR: state_reg <= ST_WDATA;
                                            `QPCD_OP_INCDEC: if (rx_r0) state_reg <= ST_STEP;
                                            `QPCD_OP_XFR_S2W: begin
                                                wiper_position_reg[rx_byte[1:0]] <=
                                                    stored_setting_reg[{rx_byte[1:0], rx_byte[3:2]}];
                                                settle_cnt_reg <= SETTLE_CYC[15:0];
                                            end
                                            `QPCD_OP_GXFR_S2W: if (rx_p0) begin
                                                for (i = 0; i < 4; i = i + 1) begin
                                                    wiper_position_reg[i] <=
                                                        stored_setting_reg[{i[1:0], rx_byte[3:2]}];
                                                end
                                                settle_cnt_reg <= SETTLE_CYC[15:0];
                                            end
                                            `QPCD_OP_XFR_W2S: begin
                                                pend_nv_reg <= 1'b1;
                                                pend_mask_reg <= 4'h1 << rx_byte[1:0];
                                                pend_rsel_reg <= rx_byte[3:2];
                                                pend_data_use_reg <= 1'b0;
                                            end
                                            `QPCD_OP_GXFR_W2S: if (rx_p0) begin
                                                pend_nv_reg <= 1'b1;
                                                pend_mask_reg <= 4'hF;
                                                pend_rsel_reg <= rx_byte[3:2];
                                                pend_data_use_reg <= 1'b0;
                                            end
                                            default: ack_reg <= 1'b1;
                                        endcase
                                    end
                                    ST_WDATA: begin
                                        ack_reg <= 1'b1;
                                        state_reg <= ST_IDLE;
                                        if (opc == `QPCD_OP_WR_WPR) begin
                                            wiper_position_reg[psel] <= rx_byte;
                                        end else begin
                                            pend_nv_reg <= 1'b1;
                                            pend_mask_reg <= 4'h1 << psel;
                                            pend_rsel_reg <= rsel;
                                            pend_data_reg <= rx_byte;
                                            pend_data_use_reg <= 1'b1;
                                        end
                                    end
                                    default: state_reg <= ST_IDLE;
                                endcase
                            end
                        end
                    end
                    ST_RDATA: begin
                        // Byte out MSB first, line changes while clock low
                        if (ack_reg) begin
                            if (scl_fall && !drive_reg) begin
                                drive_reg <= 1'b1;
                            end else if (scl_fall) begin
                                ack_reg <= 1'b0;
                                shift_reg <= (opc == `QPCD_OP_RD_WPR) ? sel_wpr : stored_setting_reg[ssr_idx];
                                drive_reg <= ~((opc == `QPCD_OP_RD_WPR) ? sel_wpr[7] : stored_setting_reg[ssr_idx][7]);
                                bit_cnt_reg <= 4'h0;
                            end
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == 4'h7) begin
                                drive_reg <= 1'b0;
                                state_reg <= ST_IDLE;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                drive_reg <= ~shift_reg[6];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    ST_STEP: begin
                        if (ack_reg) begin
                            if (scl_fall) begin
                                ack_reg <= ~drive_reg;
                                drive_reg <= ~drive_reg;
                            end
                        end else if (scl_rise) begin
                            if (sda_s && sel_wpr != `QPCD_POS_MAX) begin
                                wiper_position_reg[psel] <= sel_wpr + 8'h01;
                            end else if (!sda_s && sel_wpr != `QPCD_POS_MIN) begin
                                wiper_position_reg[psel] <= sel_wpr - 8'h01;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // qpcd_decoder

// ==== test/qpcd_decoder_monitor.sv ====
`timescale 1ns/10ps
module qpcd_monitor (
    // Clock, reset, enable
    input wire core_clk,
    input wire srst,
    input wire clk_en,
    // Bus pins
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    // Device pins and outputs
    input wire [3:0] device_addr_inputs,
    input wire write_protect_n,
    input wire [31:0] wiper_out,
    input wire nv_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    a_sda_open_drain: assert property (sda_out == 1'b0) else $error("sda_out driven high");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("sda pulled with scl high");
    a_release_scl_low: assert property ($fell(sda_oe) |-> !scl_in) else $error("sda freed with scl high");
    a_busy_no_ack: assert property (nv_busy |-> !sda_oe) else $error("sda driven while busy");
    a_busy_min_time: assert property ($rose(nv_busy) |=> nv_busy [*8]) else $error("busy too short");
    a_busy_needs_wp: assert property ($rose(nv_busy) |-> write_protect_n) else $error("write under protect");
    a_reset_clears: assert property (disable iff (1'b0) $past(srst) && $past(clk_en) |->
        wiper_out == 32'h0000_0000 && !nv_busy && !sda_oe) else $error("reset state wrong");
    // Frozen enable must hold wiper_out and sda_oe
    a_freeze_hold: assert property (!clk_en |=> $stable(wiper_out) && $stable(sda_oe))
        else $error("state moved while frozen");
endmodule // qpcd_monitor

bind qpcd_decoder qpcd_monitor mon (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .device_addr_inputs(device_addr_inputs),
    .write_protect_n(write_protect_n), .wiper_out(wiper_out), .nv_busy(nv_busy));

// ==== test/qpcd_host_model.sv ====
`timescale 1ns/10ps
module qpcd_host_model (
    // Bus lines, pulled up outside
    output logic scl,
    output logic sda_low,
    input wire logic sda,
    // Each acknowledge bit or read byte seen
    output logic [7:0] rslt,
    output logic rslt_stb
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rslt = 8'h00;
        rslt_stb = 1'b0;
    end
    task automatic report(input logic [7:0] v);
        rslt = v;
        rslt_stb = 1'b1;
        #1 rslt_stb = 1'b0;
    endtask
    // Data moves only while scl is low; scl idles high between frames
    task automatic bit_out(input logic b);
        sda_low = !b;
        #12 scl = 1'b1;
        #24 scl = 1'b0;
        #12;
    endtask
    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        #12 scl = 1'b1;
        #12 b = sda;
        #12 scl = 1'b0;
        #12;
    endtask
    task automatic start();
        #12 sda_low = 1'b1;
        #24 scl = 1'b0;
        #12;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #12 scl = 1'b1;
        #12 sda_low = 1'b0;
        #24;
    endtask
    task automatic wbyte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_in(a);
        report({7'b000_0000, a});
    endtask
    task automatic rbyte();
        logic [7:0] b;
        for (int i = 7; i >= 0; i--) bit_in(b[i]);
        report(b);
        bit_out(1'b1);
    endtask
endmodule // qpcd_host_model

// ==== test/quad_pot_command_decoder_tb.sv ====
`timescale 1ns/10ps
`include "qpcd_defs.vh"
module quad_pot_command_decoder_tb;
    logic core_clk, srst, clk_en, write_protect_n;
    logic [3:0] device_addr_inputs;
    logic [7:0] addr, rsel;
    logic [7:0] wv [4];
    logic [3:0] unl [7];
    logic [7:0] expq [$];
    int err_total, check_count;
    wire scl, m_low, sda_out, sda_oe, nv_busy, rslt_stb;
    wire [31:0] wiper_out;
    wire [7:0] rslt;
    wire sda = !(m_low || (sda_oe && !sda_out));

    qpcd_decoder DUT (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .device_addr_inputs(device_addr_inputs),
        .write_protect_n(write_protect_n), .wiper_out(wiper_out), .nv_busy(nv_busy));
    qpcd_host_model m (.scl(scl), .sda_low(m_low), .sda(sda), .rslt(rslt), .rslt_stb(rslt_stb));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = !core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // An empty queue yields an unknown note, which never matches
    always @(posedge rslt_stb) begin
        check(32'(rslt), (expq.size() > 0) ? 32'(expq.pop_front()) : 32'hxxxx_xxxx);
    end
    // Kind 0: no data byte, 1: write byte, 2: read byte
    task automatic frame(input logic [7:0] ins, input logic [7:0] dat, input logic [1:0] kind);
        expq.push_back(8'h00);
        expq.push_back(8'h00);
        m.start();
        m.wbyte(addr);
        m.wbyte(ins);
        if (kind != 2'd0)
            expq.push_back((kind == 2'd1) ? 8'h00 : dat);
        if (kind == 2'd1)
            m.wbyte(dat);
        else if (kind == 2'd2)
            m.rbyte();
        m.stop();
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (90000) @(posedge core_clk);
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(28));
        srst = 1'b1;
        clk_en = 1'b1;
        write_protect_n = 1'b1;
        device_addr_inputs = 4'h0;
        err_total = 0;
        check_count = 0;
        unl = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
        wait_clk(8);
        srst = 1'b0;
        device_addr_inputs = 4'($urandom);
        addr = {`QPCD_TYPE_ID, device_addr_inputs};
        rsel = 8'($urandom) & 8'h0C;
        wait_clk(4);
        for (int p = 0; p < 4; p++) begin
            wv[p] = 8'($urandom) | 8'h80;
            // Volatile writes must not care about write protect
            write_protect_n = 1'($urandom);
            frame({4'hA, 2'b00, 2'(p)}, wv[p], 2'd1);
        end
        check(wiper_out, {wv[3], wv[2], wv[1], wv[0]});
        for (int p = 0; p < 4; p++) frame({4'h9, 2'b00, 2'(p)}, wv[p], 2'd2);
        frame({4'hB, 4'($urandom)}, 8'h00, 2'd2);
        expq.push_back(8'h01);
        m.start();
        m.wbyte(addr ^ (8'h01 << ($urandom % 4)));
        m.stop();
        foreach (unl[i]) frame({unl[i], 4'($urandom)}, 8'h00, 2'd0);
        check(wiper_out, {wv[3], wv[2], wv[1], wv[0]});
        frame(8'hA1, 8'hFE, 2'd1);
        expq.push_back(8'h00);
        expq.push_back(8'h00);
        m.start();
        m.wbyte(addr);
        m.wbyte(8'h21);
        repeat (3) m.bit_out(1'b1);
        wait_clk(4);
        check(32'(wiper_out[15:8]), 32'h0000_00FF);
        repeat (2) m.bit_out(1'b0);
        wait_clk(4);
        check(32'(wiper_out[15:8]), 32'h0000_00FD);
        check(32'(wiper_out[7:0]), 32'(wv[0]));
        m.stop();
        frame({4'hD, rsel[3:0]}, 8'h00, 2'd0);
        check(32'(wiper_out[7:0]), 32'(wv[0]));
        wait_clk(`QPCD_SETTLE_CYC + 10);
        check(32'(wiper_out[7:0]), 32'h0000_0000);
        frame({4'h1, rsel[3:0]}, 8'h00, 2'd0);
        wait_clk(`QPCD_SETTLE_CYC + 10);
        check(wiper_out, 32'h0000_0000);
        clk_en = 1'b0;
        wait_clk(3);
        clk_en = 1'b1;
        write_protect_n = 1'b0;
        frame({4'hC, rsel[3:0]}, 8'h5A, 2'd1);
        frame({4'h8, rsel[3:0]}, 8'h00, 2'd0);
        wait_clk(20);
        check(32'(nv_busy), 32'h0000_0000);
        frame({4'hB, rsel[3:0]}, 8'h00, 2'd2);
        write_protect_n = 1'b1;
        wait_clk(4);
        frame({4'hE, rsel[3:0]}, 8'h00, 2'd0);
        wait_clk(20);
        check(32'(nv_busy), 32'h0000_0001);
        expq.push_back(8'h01);
        m.start();
        m.wbyte(addr);
        m.stop();
        for (int i = 0; i < 200 && expq.size() > 0; i++) wait_clk(1);
        if (expq.size() > 0)
            err_total++;
        conclude();
    end
endmodule // quad_pot_command_decoder_tb
